// >>> bench/host_model.sv
/* Host controller model on the register port, one-cycle strobes.
   Assumes the bench calls xfer hierarchically, after a clock edge. */
module host_model
  import rail_slew_pkg::*;
(
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Register port
  output reg_req_type     req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;

  // Held until the taking edge; idle bus shows inverted bits, never stale
  // Buck lowering with light-load skip is never commanded here
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] q);
    @(posedge clk);
    #1;
    req.addr  = a;
    req.wdata = (w && a == 8'h19 && d[5:0] > 6'h34) ? {d[7:6], 6'h34} : d;
    req.wr    = w;
    req.rd    = !w;
    @(posedge clk);
    #1;
    q   = reg_rdata;
    req = {~a, ~d, 2'b00};
  endtask
endmodule

// >>> bench/rail_slew_and_ldo_regs_tb.sv
/* Self-checking bench for the ramp and linear setpoint registers.
   Assumes host_model drives the port; short counts for speed. */
module rail_slew_and_ldo_regs_tb;
  import rail_slew_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLANK = 50;
  localparam int STEP  = 3;
  logic        clk, rst, write_unlocked, blank, bb_blank, bb_skip;
  logic  [5:0] sp1, sp2, lvl1, lvl2, ldo_code, old, bb_code;
  logic  [1:0] upd, busy;
  logic  [7:0] rdata, q, d;
  reg_req_type req;
  int          error_cnt, compares, seed, n;

  host_model host (.clk(clk), .reg_rdata(rdata), .req(req));
  rail_slew_and_ldo_regs #(.BLANK_CYCLES(BLANK), .STEP_CYCLES(STEP)) dut (
    .clk(clk), .rst(rst), .req(req), .reg_rdata(rdata),
    .write_unlocked(write_unlocked), .buck_rail_one_setpoint(sp1),
    .buck_rail_two_setpoint(sp2), .buck_setpoint_update(upd),
    .buck_rail_one_level(lvl1), .buck_rail_two_level(lvl2),
    .buck_ramp_busy(busy), .linear_reg_rail_code(ldo_code),
    .buckboost_rail_code(bb_code), .buckboost_light_load_skip(bb_skip),
    .linear_reg_monitor_blank(blank), .buckboost_monitor_blank(bb_blank));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.xfer(a, v, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(a, 8'h00, 1'b0, q);
  endtask
  // Cycles until rail one leaves a level; a hang ends the run
  task automatic wait_move(input logic [5:0] from);
    n = 0;
    while (lvl1 === from) begin
      tick();
      n++;
      if (n > 300) begin
        error_cnt++;
        final_report();
      end
    end
  endtask
  task automatic wait_idle();
    n = 0;
    while (busy !== 2'b00) begin
      tick();
      n++;
      if (n > 20000) begin
        error_cnt++;
        final_report();
      end
    end
  endtask
  // Cycles per code step for a rate code below 7
  function automatic int step_time(input int r);
    return STEP << (6 - r);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 36;
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    write_unlocked = 1'b0;
    sp1 = 6'h00;
    sp2 = 6'h00;
    upd = 2'b00;
    repeat (8) tick();
    rst = 1'b0;
    // Reset values, unmapped offset, reserved bits
    rd(8'h1a); chk(q, 8'h06);
    rd(8'h1b); chk(q, 8'h1f);
    rd(8'h19); chk(q, 8'hb2);
    rd(8'h55); chk(q, 8'h00);
    wr(8'h1a, 8'h38); rd(8'h1a); chk(q, 8'h00);
    // Locked write refused without blanking
    wr(8'h1b, 8'h05); chk({7'h00, blank}, 8'h00);
    rd(8'h1b); chk(q, 8'h1f);
    // Accepted write: applied at once, blank for the full window
    write_unlocked = 1'b1;
    d = 8'($random(seed));
    wr(8'h1b, d);
    chk({2'b00, ldo_code}, {2'b00, d[5:0]});
    n = 0;
    while (blank === 1'b1 && n < BLANK + 5) begin
      tick();
      n++;
    end
    chk(8'(n), 8'(BLANK));
    rd(8'h1b); chk(q, {2'b00, d[5:0]});
    // Buck-boost write: host keeps the code in range, applied unpaced
    wr(8'h19, 8'hff);
    chk({bb_skip, bb_blank, bb_code}, 8'hf4);
    rd(8'h19); chk(q, 8'hb4);
    // Every paced rate: step period, final level, start bit clears
    for (int r = 0; r < 7; r++) begin
      wr(8'h1a, 8'(r));
      old = lvl1;
      sp1 = lvl1 + 6'(2 + ($random(seed) & 1));
      sp2 = lvl2 ^ 6'h03;
      wr(8'h1a, 8'h80 | 8'(r));
      wait_move(old);
      wait_move(old + 6'h01);
      chk(8'(n), 8'(step_time(r)));
      wait_idle();
      chk({lvl2, lvl1[1:0]}, {sp2, sp1[1:0]});
      chk({2'b00, lvl1}, {2'b00, sp1});
      tick();
      rd(8'h1a); chk(q, 8'(r));
    end
    // Immediate code jumps straight to the setpoints
    wr(8'h1a, 8'h07);
    sp1 = 6'($random(seed));
    sp2 = 6'($random(seed));
    wr(8'h1a, 8'h87);
    chk({lvl1, busy}, {sp1, 2'b00});
    chk({2'b00, lvl2}, {2'b00, sp2});
    tick();
    rd(8'h1a); chk(q, 8'h07);
    // Bypass: an update alone starts rail one, start bit stays clear
    wr(8'h1a, 8'h46);
    sp1 = lvl1 + 6'h02;
    upd = 2'b01;
    tick();
    upd = 2'b00;
    chk({6'h00, busy}, 8'h01);
    wait_idle();
    chk({2'b00, lvl1}, {2'b00, sp1});
    rd(8'h1a); chk(q, 8'h46);
    // Without bypass an update does nothing
    wr(8'h1a, 8'h06);
    sp1 = lvl1 ^ 6'h03;
    sp2 = lvl2 ^ 6'h03;
    upd = 2'b11;
    tick();
    upd = 2'b00;
    chk({6'h00, busy}, 8'h00);
    final_report();
  end
endmodule

// >>> bench/rail_slew_props.sv
/* Checker for the ramp and linear setpoint registers.
   Sees only the top module's ports; bound at the foot. */
module rail_slew_props
  import rail_slew_pkg::*;
#(
  parameter int BLANK_CYCLES = 50
) (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        rst,
  input wire reg_req_type req,
  input wire logic  [7:0] reg_rdata,
  input wire logic        write_unlocked,
  // Buck rail one
  input wire logic  [5:0] buck_rail_one_setpoint,
  input wire logic  [1:0] buck_setpoint_update,
  input wire logic  [5:0] buck_rail_one_level,
  input wire logic  [1:0] buck_ramp_busy,
  // Linear rail
  input wire logic  [5:0] linear_reg_rail_code,
  input wire logic        linear_reg_monitor_blank
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rate_sh;
  logic       byp_sh;
  logic       seen;
  int         wcnt;
  wire logic  go_wr = req.wr && req.addr == 8'h1a;
  wire logic  ldo_ok = req.wr && req.addr == 8'h1b && write_unlocked;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Shadow of rate and bypass, cycles since last accepted linear setpoint write
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_sh <= 3'h6;
      byp_sh  <= 1'b0;
      seen    <= 1'b0;
      wcnt    <= 0;
    end else begin
      if (go_wr) begin
        rate_sh <= req.wdata[2:0];
        byp_sh  <= req.wdata[6];
      end
      if (ldo_ok) begin
        seen <= 1'b1;
        wcnt <= 0;
      end else if (wcnt < BLANK_CYCLES) begin
        wcnt <= wcnt + 1;
      end
    end
  end

  a_blank_window: assert property (linear_reg_monitor_blank == (seen && wcnt < BLANK_CYCLES))
    else $error("blank window wrong length");
  a_ldo_apply: assert property (ldo_ok |=> linear_reg_rail_code == $past(req.wdata[5:0]))
    else $error("linear code not applied at once");
  a_ldo_locked: assert property (req.wr && req.addr == 8'h1b && !write_unlocked |=> $stable(linear_reg_rail_code))
    else $error("locked write changed the linear code");
  a_rsvd_ramp: assert property (req.rd && req.addr == 8'h1a |=> reg_rdata[5:3] == 3'h0)
    else $error("ramp reserved bits not zero");
  a_rsvd_ldo: assert property (req.rd && req.addr == 8'h1b |=> reg_rdata[7:6] == 2'h0)
    else $error("linear reserved bits not zero");
  a_go_starts: assert property (go_wr && req.wdata[7] && rate_sh != 3'h7 && buck_rail_one_setpoint != buck_rail_one_level |=> buck_ramp_busy[0])
    else $error("start bit did not start the ramp");
  a_imm_apply: assert property (go_wr && req.wdata[7] && rate_sh == 3'h7 |=> buck_rail_one_level == buck_rail_one_setpoint && !buck_ramp_busy[0])
    else $error("immediate code did not apply at once");
  a_step_size: assert property ($changed(buck_rail_one_level) && buck_ramp_busy[0] && rate_sh != 3'h7 |-> 6'(buck_rail_one_level - $past(buck_rail_one_level)) inside {6'h01, 6'h3f})
    else $error("paced step larger than one code");
  a_step_space: assert property ($changed(buck_rail_one_level) && rate_sh != 3'h7 |=> $stable(buck_rail_one_level)[*2])
    else $error("paced steps too close");
  a_bypass_go: assert property (byp_sh && buck_setpoint_update[0] && !go_wr && rate_sh != 3'h7 && buck_rail_one_setpoint != buck_rail_one_level |=> buck_ramp_busy[0])
    else $error("bypass update did not start the ramp");
  a_no_bypass: assert property (!byp_sh && buck_setpoint_update[0] && !go_wr && !buck_ramp_busy[0] |=> !buck_ramp_busy[0])
    else $error("update started a ramp without bypass");

  c_go: cover property (go_wr && req.wdata[7] ##1 buck_ramp_busy[0]);
  c_bypass: cover property (byp_sh && buck_setpoint_update[0]);
  c_blank: cover property ($fell(linear_reg_monitor_blank));
endmodule

bind rail_slew_and_ldo_regs rail_slew_props #(.BLANK_CYCLES(BLANK_CYCLES)) props (
  .clk, .rst, .req, .reg_rdata, .write_unlocked, .buck_rail_one_setpoint,
  .buck_setpoint_update, .buck_rail_one_level, .buck_ramp_busy,
  .linear_reg_rail_code, .linear_reg_monitor_blank
);

// >>> rtl/rail_slew_and_ldo_regs.sv
/*
  Ramp control, linear regulator setpoint and buck-boost setpoint
  registers with the buck rail ramp pacing and monitor blanking.
  Assumes the serial bus slave presents one-cycle read and write
  strobes on an internal byte port, and that the password logic
  outside drives write_unlocked.
*/
`include "rail_slew_consts.svh"

module rail_slew_and_ldo_regs
  import rail_slew_pkg::*;
#(
  parameter int         BLANK_CYCLES     = `BLANK_CYCLES,
  parameter int         STEP_CYCLES      = `STEP_MIN_CYCLES,
  parameter logic [5:0] BUCK_LEVEL_RESET = 6'h00
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire reg_req_type req,
  output logic       [7:0] reg_rdata,
  // Write protection from the password logic
  input  wire logic        write_unlocked,
  // Buck rail setpoints held elsewhere
  input  wire logic  [5:0] buck_rail_one_setpoint,
  input  wire logic  [5:0] buck_rail_two_setpoint,
  input  wire logic  [1:0] buck_setpoint_update,
  // Paced buck rail levels
  output logic       [5:0] buck_rail_one_level,
  output logic       [5:0] buck_rail_two_level,
  output logic       [1:0] buck_ramp_busy,
  // Unpaced rails
  output logic       [5:0] linear_reg_rail_code,
  output logic       [5:0] buckboost_rail_code,
  output logic             buckboost_light_load_skip,
  // Monitor blanking
  output logic             linear_reg_monitor_blank,
  output logic             buckboost_monitor_blank
);

  bank_state_type state;
  bank_state_type next_state;
  logic     [1:0] start_rail;
  logic     [5:0] rail_setpoint [2];
  logic     [5:0] rail_level    [2];
  logic           go_write;
  logic           ldo_write;
  logic           bb_write;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(
    input reg_req_type r,
    input logic  [7:0] offset
  );
    return r.addr == offset;
  endfunction

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Protected registers drop the write silently when locked.
  assign go_write  = req.wr && hit(req, `RAMP_CONTROL_OFFSET)
                     && req.wdata[`RAMP_START_BIT];
  assign ldo_write = req.wr && hit(req, `LINEAR_REG_OFFSET)
                     && write_unlocked;
  assign bb_write  = req.wr && hit(req, `BUCKBOOST_OFFSET)
                     && write_unlocked;

  // ----------------------------------------------------------------
  // Ramp launch for each buck rail
  // ----------------------------------------------------------------
  // Bypass uses the stored bit, so a write that sets bypass does not
  // itself count as a setpoint update.
  assign rail_setpoint[0] = buck_rail_one_setpoint;
  assign rail_setpoint[1] = buck_rail_two_setpoint;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rail
      assign start_rail[gi] = go_write
        || (state.ramp.ramp_start_bypass
            && buck_setpoint_update[gi]);

      // Only the two buck rails pass through a pacer
      ramp_pacer #(
        .STEP_CYCLES (STEP_CYCLES),
        .LEVEL_RESET (BUCK_LEVEL_RESET)
      ) u_pacer (
        .clk    (clk),
        .rst    (rst),
        .start  (start_rail[gi]),
        .target (rail_setpoint[gi]),
        .rate   (state.ramp.rate),
        .level  (rail_level[gi]),
        .busy   (buck_ramp_busy[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Ramp control register
    if (req.wr && hit(req, `RAMP_CONTROL_OFFSET)) begin
      next_state.ramp.ramp_start_bypass =
        req.wdata[`RAMP_BYPASS_BIT];
      next_state.ramp.rate = req.wdata[2:0];
    end
    next_state.ramp.reserved = 3'h0;

    // A new start beats completion in the same cycle; writing 0 to
    // the start bit is a no-change, so only completion clears it.
    if (go_write) begin
      next_state.ramp.ramp_start = 1'b1;
    end else if (state.ramp.ramp_start && (buck_ramp_busy == 2'b00)) begin
      next_state.ramp.ramp_start = 1'b0;
    end

    // Linear regulator setpoint
    if (ldo_write) begin
      next_state.ldo.code = req.wdata[5:0];
    end
    next_state.ldo.reserved = 2'h0;

    // Buck-boost setpoint, applied without pacing
    if (bb_write) begin
      next_state.bb.light_load_skip = req.wdata[7];
      next_state.bb.code = req.wdata[5:0];
    end
    next_state.bb.reserved = 1'b0;

    // Each blanking counter restarts on every accepted write to its own register
    if (ldo_write) begin
      next_state.ldo_blank = `BLANK_CNT_W'(BLANK_CYCLES);
    end else if (state.ldo_blank != '0) begin
      next_state.ldo_blank = state.ldo_blank - `BLANK_CNT_W'(1);
    end
    if (bb_write) begin
      next_state.bb_blank = `BLANK_CNT_W'(BLANK_CYCLES);
    end else if (state.bb_blank != '0) begin
      next_state.bb_blank = state.bb_blank - `BLANK_CNT_W'(1);
    end

    // Read data, zero for unmapped offsets
    if (req.rd) begin
      if (hit(req, `RAMP_CONTROL_OFFSET)) begin
        next_state.rdata = state.ramp;
      end else if (hit(req, `LINEAR_REG_OFFSET)) begin
        next_state.rdata = state.ldo;
      end else if (hit(req, `BUCKBOOST_OFFSET)) begin
        next_state.rdata = state.bb;
      end else begin
        next_state.rdata = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state.ramp      <= `RAMP_CONTROL_RESET;
      state.ldo       <= `LINEAR_REG_RESET;
      state.bb        <= `BUCKBOOST_RESET;
      state.ldo_blank <= '0;
      state.bb_blank  <= '0;
      state.rdata     <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                 = state.rdata;
  assign buck_rail_one_level       = rail_level[0];
  assign buck_rail_two_level       = rail_level[1];
  assign linear_reg_rail_code      = state.ldo.code;
  assign buckboost_rail_code       = state.bb.code;
  assign buckboost_light_load_skip = state.bb.light_load_skip;
  assign linear_reg_monitor_blank  = (state.ldo_blank != '0);
  assign buckboost_monitor_blank   = (state.bb_blank != '0);

endmodule

// >>> rtl/rail_slew_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the rail
  ramp-control and linear-regulator setpoint registers.
  Assumes a 50 MHz clock and byte-wide registers on an internal port.
*/
// Summary of operation
// - Ramp-start bit clears itself after transition
// - Ramp-start write ramps both buck rails
// - Bypass bit lets setpoint updates start ramp
// - Ramp rate paces only buck rails
// - Rate codes 0-6 give 160 to 2.5 us/step
// - Rate code 7 applies setpoint at once
// - Ramp control at 0x1A, reset 0x6
// - Linear setpoint writes need write unlock
// - Linear setpoint write blanks monitoring 5 ms
// - Linear setpoint at 0x1B, reset 0x1F
// - Linear code is 0.900 V plus 25 mV steps
// - Buck-boost setpoint bits 5-0, reset 32h
`ifndef RAIL_SLEW_CONSTS_SVH
`define RAIL_SLEW_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BUCKBOOST_OFFSET      8'h19
`define RAMP_CONTROL_OFFSET   8'h1a
`define LINEAR_REG_OFFSET     8'h1b

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define BUCKBOOST_RESET       8'hb2
`define RAMP_CONTROL_RESET    8'h06
`define LINEAR_REG_RESET      8'h1f
`define RAMP_START_BIT        7
`define RAMP_BYPASS_BIT       6
`define RATE_FASTEST          3'h6
`define RATE_IMMEDIATE        3'h7
`define BUCKBOOST_TOP_CODE    6'h34

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS         20
`define CLK_FREQ_KHZ          50000
`define STEP_MIN_TIME_NS      2500
`define BLANK_TIME_MS         5
`define STEP_MIN_CYCLES  ((`STEP_MIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_CYCLES          (`BLANK_TIME_MS * `CLK_FREQ_KHZ)
`define BLANK_CNT_W           20
`define STEP_CNT_W            16

`endif

// >>> rtl/rail_slew_pkg.sv
/*
  Types shared by the ramp pacer and the register bank.
  Assumes rail_slew_consts.svh is on the include path.
*/
`include "rail_slew_consts.svh"

package rail_slew_pkg;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ramp_start;
    logic       ramp_start_bypass;
    logic [2:0] reserved;
    logic [2:0] rate;
  } ramp_control_type;

  typedef struct packed {
    logic [1:0] reserved;
    logic [5:0] code;
  } linear_reg_type;

  typedef struct packed {
    logic       light_load_skip;
    logic       reserved;
    logic [5:0] code;
  } buckboost_type;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  // ----------------------------------------------------------------
  // Pacer state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    pacer_idle,
    pacer_stepping
  } pacer_phase_type;

  typedef struct packed {
    pacer_phase_type         phase;
    logic [5:0]              level;
    logic [5:0]              goal;
    logic [`STEP_CNT_W-1:0]  count;
  } pacer_state_type;

  // ----------------------------------------------------------------
  // Register bank state
  // ----------------------------------------------------------------
  typedef struct packed {
    ramp_control_type        ramp;
    linear_reg_type          ldo;
    buckboost_type           bb;
    logic [`BLANK_CNT_W-1:0] ldo_blank;
    logic [`BLANK_CNT_W-1:0] bb_blank;
    logic [7:0]              rdata;
  } bank_state_type;

endpackage

// >>> rtl/ramp_pacer.sv
/*
  Steps one buck rail's applied setpoint code toward a latched goal at
  the programmed time per step.
  Assumes start is a one-cycle pulse and target is valid with it.
*/
`include "rail_slew_consts.svh"

module ramp_pacer
  import rail_slew_pkg::*;
#(
  parameter int         STEP_CYCLES = `STEP_MIN_CYCLES,
  parameter logic [5:0] LEVEL_RESET = 6'h00
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic [5:0] target,
  input  wire logic [2:0] rate,
  // Applied level
  output logic      [5:0] level,
  output logic            busy
);

  pacer_state_type state;
  pacer_state_type next_state;

  // ----------------------------------------------------------------
  // Cycles per step for a rate code
  // ----------------------------------------------------------------
  function automatic logic [`STEP_CNT_W-1:0] step_cycles(
    input logic [2:0] code
  );
    logic [`STEP_CNT_W-1:0] base;
    base = `STEP_CNT_W'(STEP_CYCLES);
    return base << (`RATE_FASTEST - code);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Rate is sampled at each reload, so a rate change takes effect
  // on the following step rather than restarting the ramp.
  always_comb begin
    next_state = state;
    if (start) begin
      next_state.goal = target;
      if (rate == `RATE_IMMEDIATE) begin
        next_state.level = target;
        next_state.phase = pacer_idle;
      end else begin
        next_state.phase = pacer_stepping;
        next_state.count = step_cycles(rate) - `STEP_CNT_W'(1);
      end
    end else if (state.phase == pacer_stepping) begin
      if (state.level == state.goal) begin
        next_state.phase = pacer_idle;
      end else if (rate == `RATE_IMMEDIATE) begin
        next_state.level = state.goal;
      end else if (state.count == '0) begin
        if (state.level < state.goal) begin
          next_state.level = state.level + 6'h01;
        end else begin
          next_state.level = state.level - 6'h01;
        end
        next_state.count = step_cycles(rate) - `STEP_CNT_W'(1);
      end else begin
        next_state.count = state.count - `STEP_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state.phase <= pacer_idle;
      state.level <= LEVEL_RESET;
      state.goal  <= LEVEL_RESET;
      state.count <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  assign level = state.level;
  assign busy  = (state.phase == pacer_stepping);

endmodule
